// ==== hdl/clk_rst_consts.svh ====
/*
 * Timing counts and strap bit positions for the clock source and reset sequencer.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CLK_RST_CONSTS_SVH
`define CLK_RST_CONSTS_SVH

`define CLK_PERIOD_NS 100
`define RC_WARMUP_CYCLES 1024
`define PIN_FILTER_NS 1000
`define PIN_FILTER_CYCLES ((`PIN_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_HOLD_CYCLES 4096
`define EXT_FAIL_WINDOW 16
`define WDOG_TIMEOUT 65536
`define RESTORE_WORDS 16
`define BOOT_ADDRESS 16'h0000
`define STRAP_FAMILY_BIT 0
`define STRAP_KIND_BIT 1
`define STRAP_ADDR_LSB 2
`define STRAP_ADDR_MSB 3
`define HANDOVER_LAST 3

`endif

// ==== hdl/clk_rst_pkg.sv ====
/*
 * Types shared by the clock source and reset sequencer.
 * Assumes the constants header is compiled alongside.
 */
package clk_rst_pkg;

    typedef enum logic [1:0] {
        IF_SPI,
        IF_UART,
        IF_I2C
    } serial_if_e;

    typedef enum logic [2:0] {
        SEQ_RESET,
        SEQ_HOLD,
        SEQ_RESTORE,
        SEQ_RUN
    } seq_state_e;

endpackage : clk_rst_pkg

// ==== hdl/clock_source_and_reset_sequencer.sv ====
/*
 * Clock source selection and reset sequencing for the measurement processor.
 * Assumes clk is the always-running internal RC clock (10 MHz model rate), that the external
 * clock arrives as a plain sampled input, and that the selected clock is gated downstream
 * by the one-hot select outputs.
 */
// Behaviour
// - Run from RC clock first 1024 cycles.
// - Then switch to external clock when present.
// - Fall back to RC on external failure.
// - Report external failure in status bit.
// - Reset pin must stay low 1us.
// - Clock logic keeps running during pin reset.
// - Hold reset 4096 cycles after pin high.
// - Release reset, processor fetches address zero.
// - Supply good starts reset; brownout forces it.
// - Unrefreshed watchdog expiry forces full reset.
// - Sample straps at reset, one interface active.
// - Reload saved settings from flash after reset.
`timescale 1ns/10ps
`include "clk_rst_consts.svh"

module clock_source_and_reset_sequencer #(
    parameter int RESET_HOLD = `RESET_HOLD_CYCLES,
    parameter int WDOG_LIMIT = `WDOG_TIMEOUT,
    parameter int RESTORE_WORDS = `RESTORE_WORDS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic supply_ok,
    input wire logic reset_pin_n,
    input wire logic ext_clk_in,
    input wire logic interface_family_strap,
    input wire logic serial_kind_strap,
    input wire logic address_strap_low,
    input wire logic address_strap_high,
    input wire logic wdog_refresh,
    output logic sel_rc_clk,
    output logic sel_ext_clk,
    output logic ext_osc_fail,
    output logic sys_reset_n,
    output logic [15:0] boot_address,
    output clk_rst_pkg::serial_if_e active_if,
    output logic [1:0] device_address,
    output logic restore_req,
    output logic [7:0] restore_index,
    output logic restore_busy
);

    if (RESET_HOLD < 1 || RESET_HOLD > 65535 || WDOG_LIMIT < 2 || WDOG_LIMIT > 65535 + 1 ||
        RESTORE_WORDS < 1 || RESTORE_WORDS > 256)
    begin : g_param_check
        $error("clock_source_and_reset_sequencer: parameter out of range");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0] supply_sync;
        logic [1:0] pin_sync;
        logic [1:0] ext_sync;
        logic [3:0] strap_sync0;
        logic [3:0] strap_sync1;
        logic ext_prev;
        logic [3:0] filt_cnt;
        logic [10:0] warm_cnt;
        logic warm_done;
        logic [4:0] miss_cnt;
        logic fail;
        logic use_ext;
        logic sel_rc;
        logic sel_ext;
        logic [1:0] handover;
        clk_rst_pkg::seq_state_e state;
        logic [15:0] hold_cnt;
        logic [16:0] wdog_cnt;
        logic [7:0] rest_cnt;
        logic [3:0] straps;
        logic sys_rst_n;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic pin_reset;
    logic ext_edge;

    always_comb
    begin
        st_nxt = st_r;
        pin_reset = 1'b0;
        ext_edge = 1'b0;

        // ****************************************************************
        // Input synchronisers
        // ****************************************************************
        st_nxt.supply_sync = {st_r.supply_sync[0], supply_ok};
        st_nxt.pin_sync = {st_r.pin_sync[0], reset_pin_n};
        st_nxt.ext_sync = {st_r.ext_sync[0], ext_clk_in};
        st_nxt.ext_prev = st_r.ext_sync[1];
        st_nxt.strap_sync0 = {address_strap_high, address_strap_low,
                              serial_kind_strap, interface_family_strap};
        st_nxt.strap_sync1 = st_r.strap_sync0;

        // ****************************************************************
        // Reset pin filter
        // ****************************************************************
        if (st_r.pin_sync[1])
            st_nxt.filt_cnt = '0;
        else if (st_r.filt_cnt < 4'(`PIN_FILTER_CYCLES))
            st_nxt.filt_cnt = st_r.filt_cnt + 4'h1;
        pin_reset = (st_r.filt_cnt >= 4'(`PIN_FILTER_CYCLES));

        // ****************************************************************
        // Clock source management, never held by the pin reset
        // ****************************************************************
        if (!st_r.warm_done)
        begin
            st_nxt.warm_cnt = st_r.warm_cnt + 11'h1;
            if (st_r.warm_cnt == 11'(`RC_WARMUP_CYCLES - 1))
                st_nxt.warm_done = 1'b1;
        end
        ext_edge = st_r.ext_sync[1] ^ st_r.ext_prev;
        if (ext_edge)
            st_nxt.miss_cnt = '0;
        else if (st_r.miss_cnt < 5'(`EXT_FAIL_WINDOW))
            st_nxt.miss_cnt = st_r.miss_cnt + 5'h1;
        st_nxt.fail = (st_r.miss_cnt >= 5'(`EXT_FAIL_WINDOW));
        st_nxt.use_ext = st_r.warm_done && !st_r.fail;
        // Break-before-make: drop the old select, wait, then raise the new one.
        if (st_r.use_ext != st_r.sel_ext || st_r.use_ext == st_r.sel_rc)
        begin
            st_nxt.sel_rc = 1'b0;
            st_nxt.sel_ext = 1'b0;
            st_nxt.handover = st_r.handover + 2'h1;
            if (st_r.handover == 2'(`HANDOVER_LAST))
            begin
                st_nxt.sel_ext = st_r.use_ext;
                st_nxt.sel_rc = !st_r.use_ext;
                st_nxt.handover = '0;
            end
        end

        // ****************************************************************
        // Reset sequence
        // ****************************************************************
        if (!st_r.supply_sync[1] || pin_reset || st_r.wdog_cnt == 17'(WDOG_LIMIT))
        begin
            st_nxt.state = clk_rst_pkg::SEQ_RESET;
            st_nxt.hold_cnt = '0;
            st_nxt.sys_rst_n = 1'b0;
            st_nxt.wdog_cnt = '0;
        end
        else
        begin
            case (st_r.state)
                clk_rst_pkg::SEQ_RESET:
                    if (st_r.pin_sync[1])
                        st_nxt.state = clk_rst_pkg::SEQ_HOLD;
                clk_rst_pkg::SEQ_HOLD:
                begin
                    st_nxt.hold_cnt = st_r.hold_cnt + 16'h1;
                    if (st_r.hold_cnt == 16'(RESET_HOLD - 1))
                    begin
                        st_nxt.straps = st_r.strap_sync1;
                        st_nxt.rest_cnt = '0;
                        st_nxt.state = clk_rst_pkg::SEQ_RESTORE;
                    end
                end
                clk_rst_pkg::SEQ_RESTORE:
                begin
                    st_nxt.rest_cnt = st_r.rest_cnt + 8'h1;
                    if (st_r.rest_cnt == 8'(RESTORE_WORDS - 1))
                    begin
                        st_nxt.state = clk_rst_pkg::SEQ_RUN;
                        st_nxt.sys_rst_n = 1'b1;
                    end
                end
                clk_rst_pkg::SEQ_RUN:
                    if (wdog_refresh)
                        st_nxt.wdog_cnt = '0;
                    else
                        st_nxt.wdog_cnt = st_r.wdog_cnt + 17'h1;
                default:
                    st_nxt.state = clk_rst_pkg::SEQ_RESET;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '0;
            // The pin idles high, so its synchroniser starts high to avoid a false low.
            st_r.pin_sync <= '1;
            st_r.sel_rc <= 1'b1;
            st_r.state <= clk_rst_pkg::SEQ_RESET;
        end
        else
            st_r <= st_nxt;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sel_rc_clk = st_r.sel_rc;
    assign sel_ext_clk = st_r.sel_ext;
    assign ext_osc_fail = st_r.fail;
    assign sys_reset_n = st_r.sys_rst_n;
    assign boot_address = `BOOT_ADDRESS;
    assign device_address = st_r.straps[`STRAP_ADDR_MSB:`STRAP_ADDR_LSB];
    assign restore_req = (st_r.state == clk_rst_pkg::SEQ_RESTORE);
    assign restore_busy = restore_req;
    assign restore_index = st_r.rest_cnt;

    always_comb
    begin
        if (!st_r.straps[`STRAP_FAMILY_BIT])
            active_if = clk_rst_pkg::IF_SPI;
        else if (st_r.straps[`STRAP_KIND_BIT])
            active_if = clk_rst_pkg::IF_I2C;
        else
            active_if = clk_rst_pkg::IF_UART;
    end

endmodule : clock_source_and_reset_sequencer

// ==== dv/clk_rst_sva.sv ====
/* Assertions on the ports of the clock source and reset sequencer.
   Assumes the bind below and a bench that sets RESTORE_WORDS. */
`timescale 1ns/10ps
module clk_rst_sva #(
    parameter int RESTORE_WORDS = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic supply_ok,
    input wire logic reset_pin_n,
    input wire logic ext_clk_in,
    input wire logic sel_rc_clk,
    input wire logic sel_ext_clk,
    input wire logic ext_osc_fail,
    input wire logic sys_reset_n,
    input wire logic [15:0] boot_address,
    input wire logic restore_busy,
    input wire logic restore_req,
    input wire logic [7:0] restore_index
);
    // ****************************************
    // Cycle counters and properties
    // ****************************************
    logic ext_d_r;
    logic [15:0] quiet_r;
    logic [15:0] busy_r;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ext_d_r <= 1'b0;
            quiet_r <= 16'h0000;
            busy_r <= 16'h0000;
        end
        else
        begin
            ext_d_r <= ext_clk_in;
            quiet_r <= (ext_clk_in != ext_d_r) ? 16'h0000 : quiet_r + 16'h0001;
            busy_r <= restore_busy ? busy_r + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    one_source_a: assert property (!(sel_rc_clk && sel_ext_clk)) else $error("two selects");
    ext_gap_a: assert property ($fell(sel_rc_clk) |-> !sel_ext_clk[*3] ##1 sel_ext_clk)
        else $error("bad switch to external");
    rc_gap_a: assert property ($fell(sel_ext_clk) |-> !sel_rc_clk[*3] ##1 sel_rc_clk)
        else $error("bad switch back to rc");
    restore_start_a: assert property ($rose(restore_req) |-> restore_index == 8'h00)
        else $error("restore index start");
    restore_step_a: assert property (restore_req && $past(restore_req) |->
        restore_index == $past(restore_index) + 8'h01)
        else $error("restore index step");
    busy_match_a: assert property (restore_busy == restore_req) else $error("busy mismatch");
    fail_quiet_a: assert property ($rose(ext_osc_fail) |-> quiet_r >= 16) else $error("early fail");
    boot_zero_a: assert property (boot_address == 16'h0000) else $error("boot address");
    restore_len_a: assert property ($fell(restore_busy) |-> busy_r == RESTORE_WORDS)
        else $error("restore length");
    release_after_a: assert property ($rose(sys_reset_n) |-> $past(restore_busy))
        else $error("release without restore");
    supply_drop_a: assert property (!supply_ok[*4] |-> !sys_reset_n) else $error("no brownout");
    pin_hold_a: assert property (!reset_pin_n[*8] ##1 !reset_pin_n[*7] |-> !sys_reset_n)
        else $error("pin reset missed");
endmodule : clk_rst_sva

bind clock_source_and_reset_sequencer clk_rst_sva #(.RESTORE_WORDS(RESTORE_WORDS)) i_clk_rst_sva (
    .clk(clk), .nrst(nrst), .supply_ok(supply_ok), .reset_pin_n(reset_pin_n),
    .ext_clk_in(ext_clk_in), .sel_rc_clk(sel_rc_clk), .sel_ext_clk(sel_ext_clk),
    .ext_osc_fail(ext_osc_fail), .sys_reset_n(sys_reset_n), .boot_address(boot_address),
    .restore_busy(restore_busy), .restore_req(restore_req), .restore_index(restore_index));

// ==== dv/ext_clk_board.sv ====
/* Board model: an external clock source and the interface family strap.
   Assumes the bench sets run and the wanted interface. */
`timescale 1ns/10ps
module ext_clk_board #(
    parameter int HALF_NS = 185
) (
    input wire logic run,
    input wire clk_rst_pkg::serial_if_e want_if,
    output logic ext_clk_in,
    output logic interface_family_strap
);
    // A slowed source, so the RC clock sees every level; it stops dead when off.
    // The small start offset keeps every toggle off the edges of the RC clock.
    initial
    begin
        ext_clk_in = 1'b0;
        #3;
        forever #(HALF_NS) if (run) ext_clk_in = !ext_clk_in;
    end
    assign interface_family_strap = (want_if != clk_rst_pkg::IF_SPI);
endmodule : ext_clk_board

// ==== dv/clock_source_and_reset_sequencer_tb.sv ====
/* Self-checking bench for the clock source and reset sequencer.
   Assumes the board model and the bound checker are compiled before it. */
`timescale 1ns/10ps
module clock_source_and_reset_sequencer_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic supply_ok = 1'b1;
    logic reset_pin_n = 1'b1;
    logic serial_kind_strap = 1'b0;
    logic [1:0] addr = 2'b00;
    logic wdog_refresh = 1'b0;
    logic wd_en = 1'b1;
    logic run = 1'b1;
    clk_rst_pkg::serial_if_e want_if = clk_rst_pkg::IF_SPI;
    clk_rst_pkg::serial_if_e active_if;
    logic ext_clk_in, interface_family_strap, sel_rc_clk, sel_ext_clk, ext_osc_fail;
    logic sys_reset_n, restore_req, restore_busy;
    logic [15:0] boot_address;
    logic [7:0] restore_index;
    logic [1:0] device_address;
    int miscompares = 0;
    int cmp_count = 0;
    always #50 clk = !clk;
    ext_clk_board i_ext_clk_board (.run, .want_if, .ext_clk_in, .interface_family_strap);
    clock_source_and_reset_sequencer #(.RESET_HOLD(16), .WDOG_LIMIT(64), .RESTORE_WORDS(4))
        i_clock_source_and_reset_sequencer (.clk, .nrst, .supply_ok, .reset_pin_n, .ext_clk_in,
        .interface_family_strap, .serial_kind_strap, .address_strap_low(addr[0]),
        .address_strap_high(addr[1]), .wdog_refresh, .sel_rc_clk, .sel_ext_clk, .ext_osc_fail,
        .sys_reset_n, .boot_address, .active_if, .device_address, .restore_req,
        .restore_index, .restore_busy);
    // ****************************************
    // Shared tasks and scenarios
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : cyc
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_for(input string what, input logic v, ref logic s, input int lim,
        output int n);
        for (n = 0; s !== v && n < lim; n++) cyc(1);
        chk(what, 16'(v), 16'(s));
    endtask : wait_for
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic t_clock;
        int n;
        cyc(1000);
        chk("rc in warmup", 16'h1, 16'(sel_rc_clk));
        chk("ext in warmup", 16'h0, 16'(sel_ext_clk));
        chk("boot address", 16'h0000, boot_address);
        chk("boot interface", 16'(clk_rst_pkg::IF_SPI), 16'(active_if));
        wait_for("ext select", 1'b1, sel_ext_clk, 60, n);
        run = 1'b0;
        wait_for("fail flag", 1'b1, ext_osc_fail, 60, n);
        chk("fail window", 16'h1, 16'(n >= 16));
        cyc(8);
        chk("rc fallback", 16'h1, 16'(sel_rc_clk));
        $display("clock test done");
    endtask : t_clock
    task automatic t_pin(input clk_rst_pkg::serial_if_e m, input logic [1:0] a);
        int n;
        want_if = m;
        serial_kind_strap = (m == clk_rst_pkg::IF_I2C);
        addr = a;
        reset_pin_n = 1'b0;
        cyc(6);
        reset_pin_n = 1'b1;
        cyc(8);
        chk("short pulse", 16'h1, 16'(sys_reset_n));
        reset_pin_n = 1'b0;
        cyc(20);
        chk("pin reset", 16'h0, 16'(sys_reset_n));
        chk("clock kept", 16'h1, 16'(sel_rc_clk));
        reset_pin_n = 1'b1;
        wait_for("pin release", 1'b1, sys_reset_n, 80, n);
        chk("hold length", 16'h1, 16'(n >= 20));
        chk("interface", 16'(m), 16'(active_if));
        chk("address", 16'(a), 16'(device_address));
        $display("pin test done");
    endtask : t_pin
    task automatic t_power;
        int n;
        supply_ok = 1'b0;
        cyc(4);
        chk("brownout", 16'h0, 16'(sys_reset_n));
        supply_ok = 1'b1;
        wait_for("supply release", 1'b1, sys_reset_n, 80, n);
        cyc(200);
        chk("refreshed run", 16'h1, 16'(sys_reset_n));
        wd_en = 1'b0;
        wait_for("watchdog reset", 1'b0, sys_reset_n, 90, n);
        chk("watchdog span", 16'h1, 16'(n >= 40));
        wd_en = 1'b1;
        $display("power test done");
    endtask : t_power
    always
    begin
        cyc(16);
        wdog_refresh = wd_en;
        cyc(1);
        wdog_refresh = 1'b0;
    end
    initial
    begin
        #3000000;
        miscompares++;
        end_of_test();
    end
    initial
    begin
        cyc(8);
        nrst = 1'b1;
        t_clock();
        t_pin(clk_rst_pkg::IF_SPI, 2'b01);
        t_pin(clk_rst_pkg::IF_UART, 2'b10);
        t_pin(clk_rst_pkg::IF_I2C, 2'b11);
        t_power();
        end_of_test();
    end
endmodule : clock_source_and_reset_sequencer_tb
